// ===== verilog/fcr_top.sv
// Fault collection and reaction unit with its APB register file.
// Assumes fault inputs and APB are synchronous to clk at 40 MHz.
//
// Functional notes
// - All safety-measure fault indications are collected in this one unit.
// - Each source has its own reaction setting and only that one is applied.
// - The internal reaction is none, an interrupt, or a functional reset request.
// - A recognised critical fault moves the unit to its safe state without software.
// - Collection and reaction run alone; software is involved only for interrupts.
// - Critical failures are shown on the two error output signals.
// - Both error output signals float while reset is held.
// - External reporting is always on and no setting can disable it.
// - Enable, reaction, critical, safe and timeout settings take writes only in config.
// - With the float setting at 1, entering safe state raises safeOutputsFloat; the error pair stays driven.
// - Non-critical fault status stays until cleared, which returns fault to normal.
// - The pair uses bistable signalling that the monitor decodes.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fcr_top #(
    parameter int NSRC     = fcr_pkg::NSRC_DEF,
    parameter int HALF_CYC = fcr_pkg::HEARTBEAT_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [fcr_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [NSRC-1:0]           faultIn,
    output logic                           irq,
    output logic                           funcResetReq,
    output logic                           safeState,
    output logic                           safeOutputsFloat,
    output logic      [1:0]                errorOutSignal,
    output logic      [1:0]                errorOutSignalOe
);
    import fcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations and helpers.

    fcr_state_t        stateReg;
    fcr_state_t        stateNext;
    logic [NSRC-1:0]   enableReg;
    logic [2*NSRC-1:0] reactReg;
    logic [NSRC-1:0]   critReg;
    logic              floatReg;
    logic [NSRC-1:0]   imaskReg;
    logic [NSRC-1:0]   irqStatReg;
    logic [TOUT_W-1:0] toutReg;
    logic [TOUT_W-1:0] toutCntReg;
    logic [31:0]       prdataReg;
    logic              loadedReg;
    logic              resetReqReg;
    logic              safeReg;
    logic              safeFloatReg;
    logic [31:0]       rdData;
    logic [NSRC-1:0]   irqSet;
    logic              rstHit;
    logic              accessPh;
    logic              done;
    logic              wrOk;
    logic              refused;
    logic              critHit;
    logic              ncFault;
    logic              cfgReq;
    logic              cfgExit;
    logic              toutHit;

    fcr_if #(.N(NSRC)) lk ();

    function automatic fcr_react_t reactOf(input logic [2*NSRC-1:0] r, input int i);
        return fcr_react_t'(r[2*i +: 2]);
    endfunction

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return a == ADDR_CTRL || a == ADDR_STATE || a == ADDR_ENABLE || a == ADDR_REACT
            || a == ADDR_CRIT || a == ADDR_SAFECFG || a == ADDR_FSTAT
            || a == ADDR_IMASK || a == ADDR_ISTAT || a == ADDR_TOUT;
    endfunction

    function automatic logic isCfgReg(input logic [ADDR_W-1:0] a);
        return a == ADDR_ENABLE || a == ADDR_REACT || a == ADDR_CRIT
            || a == ADDR_SAFECFG || a == ADDR_TOUT;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: read data is captured in the setup cycle, answer in the next.

    assign accessPh = psel & penable;
    assign pready   = accessPh & ce & loadedReg;
    assign done     = pready;
    assign refused  = pwrite & isCfgReg(paddr) & (stateReg != ST_CONFIG);
    assign pslverr  = pready & (~isMapped(paddr) | refused);
    assign wrOk     = done & pwrite & isMapped(paddr) & ~refused;
    assign prdata   = prdataReg;

    always_comb begin
        rdData = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL:    rdData = {31'h0, stateReg == ST_CONFIG};
            ADDR_STATE:   rdData = 32'(stateReg);
            ADDR_ENABLE:  rdData = 32'(enableReg);
            ADDR_REACT:   rdData = 32'(reactReg);
            ADDR_CRIT:    rdData = 32'(critReg);
            ADDR_SAFECFG: rdData = 32'(floatReg);
            ADDR_FSTAT:   rdData = 32'(lk.status);
            ADDR_IMASK:   rdData = 32'(imaskReg);
            ADDR_ISTAT:   rdData = 32'(irqStatReg);
            ADDR_TOUT:    rdData = 32'(toutReg);
            default:      rdData = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle so that the access cycle can
    // answer at once; the capture also arms the one-cycle ready.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdataReg <= 32'h0000_0000;
            loadedReg <= 1'b0;
        end else if (ce) begin
            if (psel && !loadedReg) begin
                prdataReg <= rdData;
            end
            loadedReg <= psel & ~done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers, writable only in the config state; the interrupt mask is writable in any state.

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enableReg <= ENABLE_RST[NSRC-1:0];
            reactReg  <= REACT_RST[2*NSRC-1:0];
            critReg   <= CRIT_RST[NSRC-1:0];
            floatReg  <= 1'b0;
            toutReg   <= TOUT_RST;
        end else if (ce && wrOk) begin
            case (paddr)
                ADDR_ENABLE:  enableReg <= pwdata[NSRC-1:0];
                ADDR_REACT:   reactReg  <= pwdata[2*NSRC-1:0];
                ADDR_CRIT:    critReg   <= pwdata[NSRC-1:0];
                ADDR_SAFECFG: floatReg  <= pwdata[SAFE_FLOAT_BIT];
                ADDR_TOUT:    toutReg   <= pwdata[TOUT_W-1:0];
                default:      ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            imaskReg <= IMASK_RST[NSRC-1:0];
        end else if (ce && wrOk && paddr == ADDR_IMASK) begin
            imaskReg <= pwdata[NSRC-1:0];
        end
    end

    // Writing ones to the fault status clears those bits.
    assign lk.clearMask = (wrOk && paddr == ADDR_FSTAT) ? pwdata[NSRC-1:0] : '0;

    fcr_fault_latch #(.N(NSRC)) uLatch (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .faultIn (faultIn),
        .lk      (lk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-source reactions on the first cycle of each fault.

    always_comb begin
        irqSet = '0;
        rstHit = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (lk.newFault[i] && enableReg[i]) begin
                if (reactOf(reactReg, i) == REACT_IRQ) begin
                    irqSet[i] = 1'b1;
                end
                if (reactOf(reactReg, i) == REACT_RESET) begin
                    rstHit = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStatReg <= '0;
        end else if (ce) begin
            irqStatReg <= (irqStatReg & ~((wrOk && paddr == ADDR_ISTAT)
                          ? pwdata[NSRC-1:0] : '0)) | irqSet;
        end
    end

    assign irq = |(irqStatReg & imaskReg);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resetReqReg <= 1'b0;
        end else if (ce) begin
            resetReqReg <= rstHit;
        end
    end

    assign funcResetReq = resetReqReg;

    ////////////////////////////////////////////////////////////////////////////
    // State machine.

    // Critical sources ignore the enable so external reporting cannot be lost.
    assign critHit = |(lk.status & critReg);
    assign ncFault = |(lk.status & ~critReg & enableReg);
    assign cfgReq  = wrOk && paddr == ADDR_CTRL && pwdata[CTRL_CFG_BIT];
    assign cfgExit = wrOk && paddr == ADDR_CTRL && !pwdata[CTRL_CFG_BIT];
    assign toutHit = toutReg != '0 && toutCntReg == toutReg;

    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            ST_NORMAL: begin
                if (critHit) begin
                    stateNext = ST_SAFE;
                end else if (ncFault) begin
                    stateNext = ST_FAULT;
                end else if (cfgReq) begin
                    stateNext = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (critHit) begin
                    stateNext = ST_SAFE;
                end else if (cfgExit || toutHit) begin
                    stateNext = ncFault ? ST_FAULT : ST_NORMAL;
                end
            end
            ST_FAULT: begin
                if (critHit) begin
                    stateNext = ST_SAFE;
                end else if (!ncFault) begin
                    stateNext = ST_NORMAL;
                end
            end
            ST_SAFE: stateNext = ST_SAFE;
            default: stateNext = ST_NORMAL;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateReg <= ST_NORMAL;
        end else if (ce) begin
            stateReg <= stateNext;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toutCntReg <= '0;
        end else if (ce) begin
            toutCntReg <= (stateReg == ST_CONFIG && !toutHit)
                          ? toutCntReg + 1'b1 : '0;
        end
    end

    // The safe flag follows the next state so the error pair drops one cycle
    // sooner; nothing but reset clears it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            safeReg      <= 1'b0;
            safeFloatReg <= 1'b0;
        end else if (ce) begin
            safeReg      <= stateNext == ST_SAFE;
            safeFloatReg <= stateNext == ST_SAFE && floatReg;
        end
    end

    assign safeState        = safeReg;
    assign safeOutputsFloat = safeFloatReg;

    fcr_error_out #(.HALF_CYC(HALF_CYC)) uErrOut (
        .clk                  (clk),
        .rst                  (rst),
        .ce                   (ce),
        .failureIndicationOut (safeReg),
        .errorOutSignal       (errorOutSignal),
        .errorOutSignalOe     (errorOutSignalOe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_cfg_lock: assert property (
        ce && done && pwrite && paddr == ADDR_ENABLE && stateReg != ST_CONFIG
        |-> pslverr ##1 $stable(enableReg))
        else $error("enable written outside config");
    chk_irq_react: assert property (
        ce && lk.newFault[0] && enableReg[0] && reactReg[1:0] == REACT_IRQ
        |=> irqStatReg[0])
        else $error("interrupt reaction not recorded");
    chk_reset_react: assert property (
        ce && lk.newFault[0] && enableReg[0] && reactReg[1:0] == REACT_RESET
        |=> funcResetReq)
        else $error("reset reaction not requested");
    chk_reset_cause: assert property (
        funcResetReq |-> $past(|lk.newFault))
        else $error("reset request without a new fault");
    chk_safe_entry: assert property (
        ce && critHit |=> stateReg == ST_SAFE ##1 safeState || !ce)
        else $error("critical fault did not reach safe state");
    chk_safe_hold: assert property (
        stateReg == ST_SAFE |=> stateReg == ST_SAFE)
        else $error("safe state left without reset");
    chk_float_out: assert property (
        ce && stateNext == ST_SAFE && floatReg |=> safeOutputsFloat && safeState)
        else $error("outputs not floated in safe state");
    chk_fault_return: assert property (
        ce && stateReg == ST_FAULT && !ncFault && !critHit |=> stateReg == ST_NORMAL)
        else $error("fault state kept after clear");
    chk_fault_entry: assert property (
        ce && stateReg == ST_NORMAL && ncFault && !critHit |=> stateReg == ST_FAULT)
        else $error("non-critical fault did not reach fault state");
    chk_tout_exit: assert property (
        ce && stateReg == ST_CONFIG && toutHit && !critHit |=> stateReg != ST_CONFIG)
        else $error("config not left at timeout");
    chk_float_off: assert property (
        ce && !floatReg |=> !safeOutputsFloat)
        else $error("outputs floated with the setting off");

    cov_config: cover property (stateReg == ST_NORMAL ##1 stateReg == ST_CONFIG);
    cov_safe: cover property (stateReg != ST_SAFE ##1 stateReg == ST_SAFE);
    cov_recover: cover property (stateReg == ST_FAULT ##1 stateReg == ST_NORMAL);
    cov_reset_req: cover property (funcResetReq);
    cov_tout_exit: cover property (stateReg == ST_CONFIG && toutHit);
endmodule
`default_nettype wire

// ===== pkg/fcr_pkg.sv
// Shared constants and types of the fault collection and reaction unit.
// Assumes a 40 MHz system clock and a byte-addressed APB register window.
package fcr_pkg;

    localparam int NSRC_DEF = 8;
    localparam int TOUT_W   = 16;
    localparam int ADDR_W   = 8;

    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATE   = 8'h04;
    localparam logic [7:0] ADDR_ENABLE  = 8'h08;
    localparam logic [7:0] ADDR_REACT   = 8'h0c;
    localparam logic [7:0] ADDR_CRIT    = 8'h10;
    localparam logic [7:0] ADDR_SAFECFG = 8'h14;
    localparam logic [7:0] ADDR_FSTAT   = 8'h18;
    localparam logic [7:0] ADDR_IMASK   = 8'h1c;
    localparam logic [7:0] ADDR_ISTAT   = 8'h20;
    localparam logic [7:0] ADDR_TOUT    = 8'h24;

    localparam int CTRL_CFG_BIT    = 0;
    localparam int SAFE_FLOAT_BIT  = 0;

    localparam logic [31:0]       ENABLE_RST = 32'h0000_0000;
    localparam logic [31:0]       REACT_RST  = 32'h0000_0000;
    localparam logic [31:0]       CRIT_RST   = 32'h0000_0000;
    localparam logic [31:0]       IMASK_RST  = 32'h0000_0000;
    localparam logic [TOUT_W-1:0] TOUT_RST   = 16'h0000;

    localparam int CLK_PERIOD_NS = 25;
    localparam int HEARTBEAT_NS  = 1000;
    localparam int HEARTBEAT_CYC = (HEARTBEAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        REACT_NONE  = 2'h0,
        REACT_IRQ   = 2'h1,
        REACT_RESET = 2'h2
    } fcr_react_t;

    typedef enum logic [3:0] {
        ST_NORMAL = 4'h1,
        ST_CONFIG = 4'h2,
        ST_FAULT  = 4'h4,
        ST_SAFE   = 4'h8
    } fcr_state_t;

endpackage

// ===== pkg/fcr_if.sv
// Link between the fault status latch and the reaction core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface fcr_if #(parameter int N = 8);
    logic [N-1:0] status;
    logic [N-1:0] newFault;
    logic [N-1:0] clearMask;
    modport latch (input clearMask, output status, output newFault);
    modport core  (output clearMask, input status, input newFault);
endinterface
`default_nettype wire

// ===== verilog/fcr_fault_latch.sv
// Sticky per-source fault status with a one-cycle new-fault pulse.
// Assumes fault inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module fcr_fault_latch #(
    parameter int N = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [N-1:0] faultIn,
    fcr_if.latch              lk
);
    logic [N-1:0] statusReg;
    logic [N-1:0] newReg;

    // A fault arriving with its clear keeps the bit set.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            statusReg <= '0;
        end else if (ce) begin
            statusReg <= (statusReg & ~lk.clearMask) | faultIn;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            newReg <= '0;
        end else if (ce) begin
            newReg <= faultIn & ~statusReg;
        end
    end

    assign lk.status   = statusReg;
    assign lk.newFault = newReg;

    chk_set_wins: assert property (@(posedge clk) disable iff (rst)
        ce && faultIn[0] |=> lk.status[0])
        else $error("fault bit lost against its clear");
endmodule
`default_nettype wire

// ===== verilog/fcr_error_out.sv
// Two-wire bistable failure signalling toward the external monitor.
// Assumes the pins float while the output enable is low.
`timescale 1ns/1ps
`default_nettype none
module fcr_error_out
    import fcr_pkg::*;
#(
    parameter int HALF_CYC = HEARTBEAT_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       failureIndicationOut,
    output logic      [1:0] errorOutSignal,
    output logic      [1:0] errorOutSignalOe
);
    logic [15:0] cntReg;
    logic        phaseReg;
    logic [1:0]  outReg;
    logic [1:0]  oeReg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cntReg   <= '0;
            phaseReg <= 1'b0;
        end else if (ce) begin
            if (cntReg == 16'(HALF_CYC - 1)) begin
                cntReg   <= '0;
                phaseReg <= ~phaseReg;
            end else begin
                cntReg <= cntReg + 16'h0001;
            end
        end
    end

    // Healthy: complementary pair alternating; failure: both held low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outReg <= 2'h0;
        end else if (ce) begin
            outReg <= failureIndicationOut ? 2'h0 : {phaseReg, ~phaseReg};
        end
    end

    // Pins stay floating while reset is held.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oeReg <= 2'h0;
        end else if (ce) begin
            oeReg <= 2'h3;
        end
    end

    assign errorOutSignal   = outReg;
    assign errorOutSignalOe = oeReg;

    chk_fail_pair: assert property (@(posedge clk) disable iff (rst)
        ce && failureIndicationOut |=> errorOutSignal == 2'h0)
        else $error("failure not shown on error pair");
    chk_pair_healthy: assert property (@(posedge clk) disable iff (rst)
        ce && !failureIndicationOut |=> errorOutSignal[0] != errorOutSignal[1])
        else $error("healthy pair not complementary");
    chk_oe_driven: assert property (@(posedge clk) disable iff (rst)
        ce |=> errorOutSignalOe == 2'h3)
        else $error("error pair not driven after reset");
endmodule
`default_nettype wire

// ===== verif/fcr_monitor.sv
// Partner model: independent monitor of the two-wire failure signalling.
// Assumes the pins sink to a pull-down level while their enables are low.
`timescale 1ns/1ps
`default_nettype none
module fcr_monitor #(
    parameter int HALF = 3
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  errPin,
    input  wire logic [1:0]  errPinOe,
    output logic             sysSafe,
    output logic      [15:0] toggles
);
    logic [1:0] pinLevel;
    logic [1:0] lastLevel;
    logic [7:0] idle;

    assign pinLevel = errPin & errPinOe;

    // Equal levels or a stalled pair both mean failure, and the safe state is then held.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sysSafe   <= 1'b0;
            toggles   <= 16'h0000;
            idle      <= 8'h00;
            lastLevel <= 2'b00;
        end else if (errPinOe == 2'b11) begin
            lastLevel <= pinLevel;
            if (pinLevel[0] == pinLevel[1] || idle > 8'(2 * HALF + 2)) begin
                sysSafe <= 1'b1;
            end
            if (pinLevel != lastLevel) begin
                toggles <= toggles + 16'h0001;
                idle    <= 8'h00;
            end else begin
                idle <= idle + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/fault_collection_reaction_tb.sv
// Self-checking bench for the fault collection and reaction unit.
// Assumes the monitor model beside the unit; every APB wait is bounded by a count.
`timescale 1ns/1ps
`default_nettype none
module fault_collection_reaction_tb;
    import fcr_pkg::*;
    localparam int HALF = 3;
    typedef struct {int src; logic irqExp; logic rstExp;} fcr_row_t;

    logic              clk, rst, ce, psel, penable, pwrite, e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, irq, funcResetReq, safeState, safeOutputsFloat;
    logic              sysSafe;
    logic [7:0]        faultIn;
    logic [1:0]        errorOutSignal, errorOutSignalOe;
    logic [15:0]       toggles;
    int                errCount, compares, n, rstCount, rstBase;
    logic [7:0]        rv[6] = '{ADDR_ENABLE, ADDR_REACT, ADDR_CRIT, ADDR_IMASK, ADDR_TOUT,
                                 ADDR_FSTAT};
    fcr_row_t          rows[5] = '{'{0, 0, 0}, '{1, 1, 0}, '{2, 0, 1}, '{3, 0, 0}, '{4, 0, 0}};

    fcr_top #(.NSRC(8), .HALF_CYC(HALF)) u_fcr_top (
        .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .faultIn(faultIn), .irq(irq), .funcResetReq(funcResetReq), .safeState(safeState),
        .safeOutputsFloat(safeOutputsFloat), .errorOutSignal(errorOutSignal),
        .errorOutSignalOe(errorOutSignalOe));

    fcr_monitor #(.HALF(HALF)) u_fcr_monitor (
        .clk(clk), .rst(rst), .errPin(errorOutSignal), .errPinOe(errorOutSignalOe),
        .sysSafe(sysSafe), .toggles(toggles));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // The reset request is a one-cycle pulse, so every pulse is counted here.
    always @(posedge clk) begin
        if (funcResetReq === 1'b1) begin
            rstCount <= rstCount + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            errCount++;
            close_out();
        end
        rd = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input int src);
        @(posedge clk);
        faultIn <= 8'h01 << src;
        @(posedge clk);
        faultIn <= 8'h00;
        repeat (4) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        faultIn = 8'h00;
        errCount = 0;
        compares = 0;
        repeat (2) @(posedge clk);
        chk("pins float in reset", 32'h0, 32'(errorOutSignalOe));
        rst <= 1'b0;
        apb(1'b1, ADDR_ENABLE, 32'h0000_000f);
        chk("write outside config", 32'h1, 32'(e));
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, 32'(e));
        foreach (rv[i]) begin
            apb(1'b0, rv[i], 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b0, ADDR_STATE, 32'h0);
        chk("state after reset", 32'h1, rd);
        $display("reset test done");
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b0, ADDR_STATE, 32'h0);
        chk("config state", 32'h2, rd);
        apb(1'b1, ADDR_ENABLE, 32'h0000_000f);
        chk("write in config", 32'h0, 32'(e));
        apb(1'b1, ADDR_REACT, 32'h0000_01e4);
        apb(1'b1, ADDR_CRIT, 32'h0000_0080);
        apb(1'b1, ADDR_SAFECFG, 32'h1);
        apb(1'b1, ADDR_IMASK, 32'h0000_00ff);
        apb(1'b0, ADDR_REACT, 32'h0);
        chk("reaction setting", 32'h0000_01e4, rd);
        apb(1'b1, ADDR_CTRL, 32'h0);
        $display("config test done");
        foreach (rows[i]) begin
            rstBase = rstCount;
            pulse(rows[i].src);
            apb(1'b0, ADDR_FSTAT, 32'h0);
            chk("fault status", 32'h1 << rows[i].src, rd);
            chk("irq", 32'(rows[i].irqExp), 32'(irq));
            chk("reset request", 32'(rows[i].rstExp), 32'(rstCount - rstBase));
            apb(1'b0, ADDR_ISTAT, 32'h0);
            chk("irq status", 32'(rows[i].irqExp) << rows[i].src, rd);
            apb(1'b1, ADDR_FSTAT, 32'h1 << rows[i].src);
            apb(1'b1, ADDR_ISTAT, 32'h1 << rows[i].src);
            repeat (2) @(posedge clk);
            apb(1'b0, ADDR_STATE, 32'h0);
            chk("back to normal", 32'h1, rd);
            chk("irq cleared", 32'h0, 32'(irq));
            $display("row %0d done", i);
        end
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        rd = 32'(errorOutSignal);
        faultIn <= 8'h20;
        repeat (2) @(posedge clk);
        faultIn <= 8'h00;
        @(posedge clk);
        chk("frozen pair", rd, 32'(errorOutSignal));
        ce <= 1'b1;
        apb(1'b0, ADDR_FSTAT, 32'h0);
        chk("fault while frozen", 32'h0, rd);
        $display("clock enable test done");
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_TOUT, 32'h0000_0040);
        chk("timeout write", 32'h0, 32'(e));
        apb(1'b0, ADDR_STATE, 32'h0);
        chk("config before timeout", 32'h2, rd);
        repeat (80) @(posedge clk);
        apb(1'b0, ADDR_STATE, 32'h0);
        chk("config timed out", 32'h1, rd);
        $display("timeout test done");
        chk("healthy pair", 32'h0, 32'(sysSafe));
        chk("pair toggles", 32'h1, 32'(toggles != 16'h0000));
        pulse(7);
        for (n = 0; n < 20 && safeState !== 1'b1; n++) begin
            @(posedge clk);
        end
        chk("safe state out", 32'h1, 32'(safeState));
        repeat (2) @(posedge clk);
        chk("outputs float", 32'h1, 32'(safeOutputsFloat));
        chk("failure level", 32'h0, 32'(errorOutSignal));
        chk("pair driven", 32'h3, 32'(errorOutSignalOe));
        chk("monitor safe", 32'h1, 32'(sysSafe));
        apb(1'b0, ADDR_STATE, 32'h0);
        chk("safe state", 32'h8, rd);
        $display("critical test done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pins float again", 32'h0, 32'(errorOutSignalOe));
        chk("safe cleared by reset", 32'h0, 32'(safeState));
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("pair driven again", 32'h3, 32'(errorOutSignalOe));
        $display("second reset test done");
        close_out();
    end
endmodule
`default_nettype wire
